//--- cantx_handler.sv
/*
 CAN transmit handler, interrupt line routing and receive FIFO 1
 configuration behind an Avalon-MM slave. Assumes a protocol engine that
 reports transmission start/success, received frames, bus idle and a
 one-cycle tick per bit time, and reads identifiers of dedicated buffers.
*/
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/1ps
`include "cantx_params.svh"

module cantx_handler #(
  parameter int NBUF = 8,
  parameter int IDW = 29
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [NBUF*IDW-1:0] buf_ids_i,
  input wire logic [NBUF-1:0] buf_fd_flag_i,
  input wire logic [NBUF-1:0] buf_rs_flag_i,
  input wire logic fifo_req_i,
  input wire logic [IDW-1:0] fifo_id_i,
  input wire logic tx_started_i,
  input wire logic tx_success_i,
  input wire logic rx_done_i,
  input wire logic bus_idle_i,
  input wire logic bit_tick_i,
  input wire logic [31:0] irq_flags_i,
  output logic tx_request_o,
  output logic tx_from_fifo_o,
  output logic [$clog2(NBUF)-1:0] tx_buf_idx_o,
  output logic [1:0] tx_format_o,
  output logic scan_start_o,
  output logic irq_line_zero_o,
  output logic irq_line_one_o,
  output logic fifo1_operation_mode_o,
  output logic fifo1_wm_enable_o,
  output logic [6:0] fifo1_watermark_o,
  output logic [6:0] fifo1_size_o,
  output logic [6:0] fifo1_last_index_o,
  output logic [13:0] fifo1_start_address_o,
  output logic irq_o
);
  localparam int IW = $clog2(NBUF);

  typedef struct packed {
    logic [31:0] ctrl;
    logic [NBUF-1:0] pending;
    logic [31:0] ils;
    logic [31:0] rxf1c;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic [31:0] rdata;
    logic ack;
    cantx_pkg::cantx_state_t state;
    logic [1:0] pause_cnt;
    logic scan;
    logic win_valid;
    logic win_fifo;
    logic [IW-1:0] win_idx;
    logic [1:0] win_fmt;
  } cantx_state_s_t;

  cantx_state_s_t st_reg;
  cantx_state_s_t st_next;

  ////////////////////////////////////////////////////////////////////////
  // Priority scan over dedicated buffers, one combinational pass
  logic [NBUF-1:0] cand;
  logic [IDW-1:0] best_id [0:NBUF];
  logic [IW-1:0] best_idx [0:NBUF];
  logic best_vld [0:NBUF];

  assign best_id[0] = '1;
  assign best_idx[0] = '0;
  assign best_vld[0] = 1'b0;

  genvar g;
  generate
    for (g = 0; g < NBUF; g++) begin : g_scan
      logic [IDW-1:0] id_g;
      logic take;
      assign id_g = buf_ids_i[g*IDW +: IDW];
      // Strict less-than keeps the lower index on a tie
      assign take = st_reg.pending[g] && (!best_vld[g] || id_g < best_id[g]); // RQ4 RQ8
      assign best_id[g+1] = take ? id_g : best_id[g];
      assign best_idx[g+1] = take ? IW'(g) : best_idx[g];
      assign best_vld[g+1] = best_vld[g] | take;
    end
  endgenerate

  // Dedicated buffer wins a tie against the FIFO entry
  logic fifo_wins;
  assign fifo_wins = fifo_req_i && (!best_vld[NBUF] || fifo_id_i < best_id[NBUF]); // RQ10

  function automatic logic [1:0] frame_fmt(input logic fd_en, input logic sw_en,
                                           input logic buf_fd, input logic buf_sw);
    logic [1:0] f;
    f = cantx_pkg::CANTX_FMT_CLASSIC; // RQ1
    if (fd_en && buf_fd) begin
      f = (sw_en && buf_sw) ? cantx_pkg::CANTX_FMT_FD_SWITCH : cantx_pkg::CANTX_FMT_FD; // RQ2
    end
    return f;
  endfunction : frame_fmt

  ////////////////////////////////////////////////////////////////////////
  // Register access and handler state
  logic hit_ctrl;
  logic hit_add;
  logic hit_irqs;
  logic hit_irqm;
  logic hit_ils;
  logic hit_rxf1c;
  logic [31:0] bmask;
  logic [31:0] wr_d;
  logic [NBUF-1:0] add_bits;
  logic [2:0] events;

  assign bmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                  {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  assign wr_d = avs_writedata_i & bmask;
  assign add_bits = wr_d[NBUF-1:0];
  assign events = {rx_done_i, tx_success_i, tx_started_i};

  always_comb begin
    logic wr;
    logic cfg_ok;
    logic [7:0] a;
    st_next = st_reg;
    // Write lands on the edge that ends the wait
    wr = avs_write_i && st_reg.ack;
    a = avs_address_i;
    cfg_ok = st_reg.ctrl[`CANTX_CTRL_CFG_EN] && st_reg.ctrl[`CANTX_CTRL_INIT];
    hit_ctrl = wr && a == `CANTX_OFS_CTRL;
    hit_add = wr && a == `CANTX_OFS_ADD_REQ;
    hit_irqs = wr && a == `CANTX_OFS_IRQ_STAT;
    hit_irqm = wr && a == `CANTX_OFS_IRQ_MASK;
    hit_ils = wr && a == `CANTX_OFS_ILS;
    hit_rxf1c = wr && a == `CANTX_OFS_RXF1C && cfg_ok; // RQ14
    st_next.ack = (avs_read_i || avs_write_i) && !st_reg.ack;
    st_next.scan = 1'b0;
    if (hit_ctrl) begin
      st_next.ctrl = (st_reg.ctrl & ~bmask) | (wr_d & `CANTX_CTRL_MASK); // RQ6
    end
    if (hit_ils) begin
      st_next.ils = (st_reg.ils & ~bmask) | (wr_d & `CANTX_ILS_MASK); // RQ11 RQ12 RQ13
    end
    if (hit_rxf1c) begin
      st_next.rxf1c = (st_reg.rxf1c & ~bmask) | (wr_d & `CANTX_RXF1C_MASK); // RQ15 RQ19
    end
    if (hit_irqm) begin
      st_next.irq_mask = wr_d[2:0];
    end
    // Event set wins over a write-one clear in the same cycle
    st_next.irq_stat = (hit_irqs ? st_reg.irq_stat & ~wr_d[2:0] : st_reg.irq_stat) | events;
    // Served buffer drops out when its transmission succeeds
    if (tx_success_i && st_reg.win_valid && !st_reg.win_fifo) begin
      st_next.pending[st_reg.win_idx] = 1'b0;
    end
    if (hit_add) begin
      st_next.pending = st_next.pending | add_bits; // RQ9
    end
    // Rescan after success too, so a FIFO winner is not kept stale
    if (st_next.pending != st_reg.pending || tx_started_i || tx_success_i) begin
      st_next.scan = 1'b1; // RQ3
    end
    if (st_reg.scan) begin
      st_next.win_valid = best_vld[NBUF] || fifo_req_i;
      st_next.win_fifo = fifo_wins;
      st_next.win_idx = best_idx[NBUF];
      st_next.win_fmt = frame_fmt(st_reg.ctrl[`CANTX_CTRL_FD_EN], st_reg.ctrl[`CANTX_CTRL_SWITCH_EN],
                                  buf_fd_flag_i[best_idx[NBUF]], buf_rs_flag_i[best_idx[NBUF]]);
    end
    unique case (st_reg.state)
      cantx_pkg::CANTX_ST_IDLE: begin
        if (tx_started_i) begin
          st_next.state = cantx_pkg::CANTX_ST_BUSY;
        end
      end
      cantx_pkg::CANTX_ST_BUSY: begin
        if (tx_success_i && st_reg.ctrl[`CANTX_CTRL_PAUSE_EN]) begin
          st_next.state = cantx_pkg::CANTX_ST_PAUSE; // RQ5
          st_next.pause_cnt = `CANTX_PAUSE_BITS;
        end else if (tx_success_i || !bus_idle_i) begin
          st_next.state = tx_success_i ? cantx_pkg::CANTX_ST_IDLE : st_reg.state;
        end
      end
      cantx_pkg::CANTX_ST_PAUSE: begin
        // Another node's frame ends the pause early; its end frees us
        if (rx_done_i) begin
          st_next.state = cantx_pkg::CANTX_ST_IDLE; // RQ7
        end else if (!bus_idle_i) begin
          st_next.pause_cnt = `CANTX_PAUSE_BITS;
        end else if (bit_tick_i) begin
          st_next.pause_cnt = st_reg.pause_cnt - 2'h1;
          if (st_reg.pause_cnt == 2'h1) begin
            st_next.state = cantx_pkg::CANTX_ST_IDLE; // RQ5
          end
        end
      end
      default: begin
        st_next.state = cantx_pkg::CANTX_ST_IDLE;
      end
    endcase
    unique case (a)
      `CANTX_OFS_CTRL: st_next.rdata = st_reg.ctrl;
      `CANTX_OFS_PENDING: st_next.rdata = 32'(st_reg.pending);
      `CANTX_OFS_STATUS: st_next.rdata = {24'h00_0000, 1'b0, st_reg.win_valid, st_reg.win_fmt,
                                          st_reg.state, st_reg.pause_cnt};
      `CANTX_OFS_IRQ_STAT: st_next.rdata = {29'h0000_0000, st_reg.irq_stat};
      `CANTX_OFS_IRQ_MASK: st_next.rdata = {29'h0000_0000, st_reg.irq_mask};
      `CANTX_OFS_ILS: st_next.rdata = st_reg.ils;
      `CANTX_OFS_RXF1C: st_next.rdata = st_reg.rxf1c;
      default: st_next.rdata = 32'h0000_0000;
    endcase
    if (tx_started_i || tx_success_i) begin
      st_next.win_valid = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  logic [6:0] size_raw;
  logic [6:0] wmark_raw;
  assign size_raw = st_reg.rxf1c[`CANTX_F1_SIZE_LSB +: 7];
  assign wmark_raw = st_reg.rxf1c[`CANTX_F1_WMARK_LSB +: 7];

  assign avs_readdata_o = st_reg.rdata;
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !st_reg.ack;
  assign tx_request_o = st_reg.win_valid && st_reg.state == cantx_pkg::CANTX_ST_IDLE;
  assign tx_from_fifo_o = st_reg.win_fifo;
  assign tx_buf_idx_o = st_reg.win_idx;
  assign tx_format_o = st_reg.win_fmt;
  assign scan_start_o = st_reg.scan;
  assign irq_line_zero_o = |(irq_flags_i & ~st_reg.ils & `CANTX_ILS_MASK); // RQ11
  assign irq_line_one_o = |(irq_flags_i & st_reg.ils); // RQ11
  assign fifo1_operation_mode_o = st_reg.rxf1c[`CANTX_F1_MODE_BIT]; // RQ15
  assign fifo1_watermark_o = wmark_raw;
  assign fifo1_wm_enable_o = wmark_raw != 7'h00 && wmark_raw <= `CANTX_FIFO_MAX; // RQ16
  assign fifo1_size_o = (size_raw > `CANTX_FIFO_MAX) ? `CANTX_FIFO_MAX : size_raw; // RQ17
  assign fifo1_last_index_o = fifo1_size_o - 7'h01; // RQ18
  assign fifo1_start_address_o = st_reg.rxf1c[15:2]; // RQ19
  assign irq_o = |(st_reg.irq_stat & st_reg.irq_mask);
endmodule : cantx_handler

//--- cantx_params.svh
/*
 CAN transmit handler and FIFO 1 configuration: register offsets, field
 positions, reset values and timing counts. Assumes a 32-bit Avalon-MM
 slave with byte addresses, and a bit-time tick from the protocol engine.
*/
// Function
// RQ1 - Classic frame when FD disabled, or FD enabled with buffer FD flag clear.
// RQ2 - FD with rate switch only when all four enables set; else plain FD.
// RQ3 - Restart priority scan on pending-register change and on transmission start.
// RQ4 - Pending buffer with lowest identifier wins the scan.
// RQ5 - With pause on, wait two idle bit times after each good transmission.
// RQ6 - Transmit pause enable resets to zero.
// RQ7 - After a received frame no extra pause is added.
// RQ8 - Equal identifiers: lowest buffer index goes first.
// RQ9 - Software sets an add-request bit after writing buffer data.
// RQ10 - Dedicated buffers compete with FIFO or queue entry by identifier.
// RQ11 - Line-select bit 0 routes flag to line zero, 1 to line one.
// RQ12 - Error line-select bits sit at positions 29 down to 22.
// RQ13 - Dedicated receive line select at bit 19; bits 31:30, 21, 20 unimplemented.
// RQ14 - FIFO 1 configuration writable only with config-change enable and init set.
// RQ15 - Bit 31 selects blocking (0) or overwrite (1) for FIFO 1.
// RQ16 - Watermark 1 to 64 sets level; 0 or above 64 disables it.
// RQ17 - Size 0 means no FIFO; above 64 clamps to 64.
// RQ18 - FIFO 1 elements indexed from zero to size minus one.
// RQ19 - Start address in bits 15:2; bits 1:0 and 23 read zero.
`ifndef CANTX_PARAMS_SVH
`define CANTX_PARAMS_SVH

`define CANTX_OFS_CTRL 8'h00
`define CANTX_OFS_ADD_REQ 8'h04
`define CANTX_OFS_PENDING 8'h08
`define CANTX_OFS_STATUS 8'h0C
`define CANTX_OFS_IRQ_STAT 8'h10
`define CANTX_OFS_IRQ_MASK 8'h14
`define CANTX_OFS_ILS 8'h58
`define CANTX_OFS_RXF1C 8'hB0

`define CANTX_CTRL_INIT 0
`define CANTX_CTRL_CFG_EN 1
`define CANTX_CTRL_PAUSE_EN 2
`define CANTX_CTRL_FD_EN 3
`define CANTX_CTRL_SWITCH_EN 4
`define CANTX_CTRL_MASK 32'h0000_001F

`define CANTX_ILS_MASK 32'h3FCF_FFFF
`define CANTX_RXF1C_MASK 32'hFF7F_FFFC
`define CANTX_F1_MODE_BIT 31
`define CANTX_F1_WMARK_LSB 24
`define CANTX_F1_SIZE_LSB 16
`define CANTX_FIFO_MAX 7'h40

`define CANTX_RESET_VAL 32'h0000_0000
`define CANTX_PAUSE_BITS 2'h2

`endif

//--- cantx_pkg.sv
/*
 Types of the CAN transmit handler. Assumes cantx_params.svh for numbers.
*/
package cantx_pkg;
  typedef enum logic [1:0] {
    CANTX_FMT_CLASSIC = 2'b00,
    CANTX_FMT_FD = 2'b01,
    CANTX_FMT_FD_SWITCH = 2'b10
  } cantx_fmt_t;

  typedef enum logic [1:0] {
    CANTX_ST_IDLE = 2'b00,
    CANTX_ST_BUSY = 2'b01,
    CANTX_ST_PAUSE = 2'b10
  } cantx_state_t;
endpackage : cantx_pkg

//--- cantx_handler_props.sv
/*
 Port-level checks on the CAN transmit handler.
 Assumes cantx_params.svh on the include path and a single clock domain.
*/
`timescale 1ns/1ps
`include "cantx_params.svh"
module cantx_handler_props #(
  parameter int NBUF = 8
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic [NBUF-1:0] buf_fd_flag_i,
  input wire logic [NBUF-1:0] buf_rs_flag_i,
  input wire logic tx_started_i,
  input wire logic [31:0] irq_flags_i,
  input wire logic tx_request_o,
  input wire logic tx_from_fifo_o,
  input wire logic [$clog2(NBUF)-1:0] tx_buf_idx_o,
  input wire logic [1:0] tx_format_o,
  input wire logic scan_start_o,
  input wire logic irq_line_zero_o,
  input wire logic irq_line_one_o,
  input wire logic fifo1_wm_enable_o,
  input wire logic [6:0] fifo1_watermark_o,
  input wire logic [6:0] fifo1_size_o,
  input wire logic [6:0] fifo1_last_index_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  ////////////////////////////////////////
  sequence s_add_req;
    avs_write_i && !avs_waitrequest_o && avs_address_i == `CANTX_OFS_ADD_REQ;
  endsequence
  sequence s_scan_soon;
    ##[1:2] scan_start_o;
  endsequence
  // Two samples: lines may lag an ILS write by one register; flags reach them directly
  sequence s_no_route_flags;
    ((irq_flags_i & `CANTX_ILS_MASK) == 32'h0000_0000) [*2];
  endsequence
  property p_wait;
    $rose(avs_read_i) || $rose(avs_write_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o;
  endproperty
  property p_scan_add;
    s_add_req |-> s_scan_soon;
  endproperty
  property p_scan_start;
    tx_started_i |-> ##[0:2] scan_start_o;
  endproperty
  property p_classic;
    tx_request_o && !tx_from_fifo_o && !buf_fd_flag_i[tx_buf_idx_o] |-> tx_format_o == 2'h0;
  endproperty
  property p_no_switch;
    tx_request_o && !tx_from_fifo_o && !buf_rs_flag_i[tx_buf_idx_o] |-> tx_format_o != 2'h2;
  endproperty
  property p_one_line;
    ($onehot(irq_flags_i & `CANTX_ILS_MASK)) [*2] |-> irq_line_zero_o != irq_line_one_o;
  endproperty
  property p_unimpl;
    s_no_route_flags |-> !irq_line_zero_o && !irq_line_one_o;
  endproperty
  property p_wm;
    fifo1_wm_enable_o == (fifo1_watermark_o != 7'h00 && fifo1_watermark_o <= `CANTX_FIFO_MAX);
  endproperty
  property p_size;
    fifo1_size_o <= `CANTX_FIFO_MAX && fifo1_last_index_o == fifo1_size_o - 7'h01;
  endproperty
  a_wait: assert property (p_wait) else $error("waitrequest not one cycle");
  a_scan_add: assert property (p_scan_add) else $error("no scan after add request");
  a_scan_start: assert property (p_scan_start) else $error("no scan after start");
  a_classic: assert property (p_classic) else $error("fd frame without fd flag");
  a_no_switch: assert property (p_no_switch) else $error("rate switch without flag");
  a_one_line: assert property (p_one_line) else $error("flag not on exactly one line");
  a_unimpl: assert property (p_unimpl) else $error("unimplemented flag routed");
  a_wm: assert property (p_wm) else $error("watermark enable wrong");
  a_size: assert property (p_size) else $error("fifo size or last index wrong");
endmodule : cantx_handler_props
bind cantx_handler cantx_handler_props #(.NBUF(NBUF)) props_u (.*);

//--- cantx_node_model.sv
/*
 Far-side bus model: starts a frame on request, reports success, ticks bits.
 Assumes the handler's request level and a free-running bit tick.
*/
`timescale 1ns/1ps
module cantx_node_model #(
  parameter int FRAME_LEN = 8
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic tx_request_i,
  output logic tx_started_o,
  output logic tx_success_o,
  output logic bit_tick_o,
  output logic bus_idle_o
);
  logic [4:0] cnt;
  logic [1:0] div;
  ////////////////////////////////////////
  // Three idle cycles after success so a stale request is not restarted
  always_ff @(posedge clk_i) begin
    div <= div + 2'h1;
    bit_tick_o <= div == 2'h3;
    tx_started_o <= 1'b0;
    tx_success_o <= 1'b0;
    if (sys_rst_i) begin
      cnt <= 5'h00;
      div <= 2'h0;
      bit_tick_o <= 1'b0;
    end else if (cnt != 5'h00) begin
      cnt <= cnt - 5'h01;
      tx_success_o <= cnt == 5'h04;
    end else if (tx_request_i) begin
      cnt <= 5'(FRAME_LEN + 4);
      tx_started_o <= 1'b1;
    end
  end
  assign bus_idle_o = cnt < 5'h04;
endmodule : cantx_node_model

//--- cantx_handler_tb.sv
/*
 Self-checking bench for the CAN transmit handler over Avalon-MM.
 Assumes cantx_node_model on the far side and cantx_params.svh.
*/
`timescale 1ns/1ps
`include "cantx_params.svh"
module cantx_handler_tb;
  logic clk_i, sys_rst_i, avs_read_i, avs_write_i, avs_waitrequest_o, fifo_req_i, rx_done_i;
  logic tx_started_i, tx_success_i, bus_idle_i, bit_tick_i, tx_request_o, tx_from_fifo_o, scan_start_o;
  logic irq_line_zero_o, irq_line_one_o, fifo1_operation_mode_o, fifo1_wm_enable_o, irq_o;
  logic [7:0] avs_address_i, buf_fd_flag_i, buf_rs_flag_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, irq_flags_i;
  logic [3:0] avs_byteenable_i;
  logic [231:0] buf_ids_i;
  logic [28:0] fifo_id_i;
  logic [2:0] tx_buf_idx_o;
  logic [1:0] tx_format_o;
  logic [6:0] fifo1_watermark_o, fifo1_size_o, fifo1_last_index_o;
  logic [13:0] fifo1_start_address_o;
  int failures = 0, n_checks = 0, cyc = 0, gap = 100;
  cantx_handler dut_u (.*);
  cantx_node_model node_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .tx_request_i(tx_request_o),
    .tx_started_o(tx_started_i), .tx_success_o(tx_success_i), .bit_tick_o(bit_tick_i), .bus_idle_o(bus_idle_i));
  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task finish_test;
    if (failures == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  // Waitrequest is looked at before the edge so no race with its update
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    logic done;
    done = 1'b0;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    while (!done) begin
      @(negedge clk_i);
      done = avs_waitrequest_o === 1'b0;
      q = avs_readdata_o;
      @(posedge clk_i);
    end
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0000_0000, q);
    check(q, exp);
  endtask : rd
  task automatic irq_chk(input logic [31:0] f, input logic [1:0] exp);
    @(posedge clk_i);
    irq_flags_i <= f;
    repeat (2) @(negedge clk_i);
    check({irq_line_zero_o, irq_line_one_o}, exp);
  endtask : irq_chk
  task automatic next_tx(input logic [2:0] idx, input logic [1:0] fmt, input logic ff, input logic paused);
    int n;
    n = 0;
    @(negedge clk_i);
    while (tx_request_o !== 1'b1 && n < 300) begin
      @(negedge clk_i);
      n++;
    end
    check(ff ? {tx_from_fifo_o} : {tx_from_fifo_o, tx_format_o, tx_buf_idx_o}, ff ? 1'b1 : {1'b0, fmt, idx});
    check(gap >= 4, paused);
    while (tx_success_i !== 1'b1 && n < 600) begin
      @(negedge clk_i);
      n++;
    end
  endtask : next_tx
  ////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    gap <= tx_success_i ? 0 : gap + 1;
    if (cyc == 5000) begin
      failures++;
      finish_test();
    end
  end
  initial begin
    sys_rst_i = 1'b1;
    {avs_read_i, avs_write_i, fifo_req_i, rx_done_i} = 4'h0;
    avs_address_i = 8'h00;
    avs_writedata_i = 32'h0000_0000;
    avs_byteenable_i = 4'hF;
    irq_flags_i = 32'h0000_0000;
    buf_ids_i = '0;
    buf_ids_i[6*29+:29] = 29'h0000_0005;
    buf_ids_i[2*29+:29] = 29'h0000_0010;
    buf_ids_i[5*29+:29] = 29'h0000_0010;
    fifo_id_i = 29'h0000_0010;
    buf_fd_flag_i = 8'h44;
    buf_rs_flag_i = 8'h40;
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(`CANTX_OFS_CTRL, `CANTX_RESET_VAL);
    rd(`CANTX_OFS_ILS, `CANTX_RESET_VAL);
    wr(`CANTX_OFS_ILS, 32'hFFFF_FFFF);
    rd(`CANTX_OFS_ILS, `CANTX_ILS_MASK);
    irq_chk(32'h2000_0000, 2'b01);
    irq_chk(32'h0010_0000, 2'b00);
    wr(`CANTX_OFS_ILS, 32'h0000_0000);
    irq_chk(32'h0008_0000, 2'b10);
    irq_chk(32'h0000_0000, 2'b00);
    wr(`CANTX_OFS_RXF1C, 32'hFFFF_FFFF);
    rd(`CANTX_OFS_RXF1C, 32'h0000_0000);
    wr(`CANTX_OFS_CTRL, 32'h0000_0003);
    wr(`CANTX_OFS_RXF1C, 32'hFFFF_FFFF);
    rd(`CANTX_OFS_RXF1C, `CANTX_RXF1C_MASK);
    check({fifo1_operation_mode_o, fifo1_wm_enable_o, fifo1_size_o, fifo1_last_index_o}, {2'b10, 7'h40, 7'h3F});
    wr(`CANTX_OFS_RXF1C, 32'h4005_0008);
    @(negedge clk_i);
    check({fifo1_operation_mode_o, fifo1_wm_enable_o, fifo1_watermark_o, fifo1_size_o, fifo1_last_index_o},
      {2'b01, 7'h40, 7'h05, 7'h04});
    check(fifo1_start_address_o, 14'h0002);
    rd(8'h20, 32'h0000_0000);
    wr(`CANTX_OFS_CTRL, 32'h0000_001C);
    wr(`CANTX_OFS_ADD_REQ, 32'h0000_0064);
    fifo_req_i <= 1'b1;
    next_tx(3'h6, 2'h2, 1'b0, 1'b1);
    next_tx(3'h2, 2'h1, 1'b0, 1'b1);
    next_tx(3'h5, 2'h0, 1'b0, 1'b1);
    @(posedge clk_i);
    rx_done_i <= 1'b1;
    @(posedge clk_i);
    rx_done_i <= 1'b0;
    next_tx(3'h0, 2'h0, 1'b1, 1'b0);
    @(posedge clk_i);
    fifo_req_i <= 1'b0;
    rd(`CANTX_OFS_PENDING, 32'h0000_0000);
    check(irq_o, 1'b0);
    wr(`CANTX_OFS_IRQ_MASK, 32'h0000_0003);
    rd(`CANTX_OFS_IRQ_STAT, 32'h0000_0007);
    check(irq_o, 1'b1);
    wr(`CANTX_OFS_IRQ_STAT, 32'h0000_0003);
    rd(`CANTX_OFS_IRQ_STAT, 32'h0000_0004);
    check(irq_o, 1'b0);
    finish_test();
  end
endmodule : cantx_handler_tb
